// ===== hw/chim_top.sv
// module: interrupt enable/mask unit of the card host controller
`timescale 1ns/1ps
module chim_top
  import chim_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              command_done,
  input  wire logic              receive_word_ready,
  input  wire logic              transmit_word_ready,
  input  wire logic              block_ended,
  input  wire logic              data_transfer_active,
  input  wire logic              card_idle,
  input  wire logic              receive_count_end,
  input  wire logic              transmit_count_end,
  input  wire logic              card_irq_slot_a,
  input  wire logic              card_irq_slot_b,
  input  wire logic              response_index_error,
  input  wire logic              response_direction_error,
  input  wire logic              response_crc_error,
  input  wire logic              response_endbit_error,
  input  wire logic              response_timeout_error,
  input  wire logic              data_crc_error,
  input  wire logic              data_timeout_error,
  input  wire logic              receive_overrun,
  input  wire logic              transmit_underrun,
  input  wire logic [15:0]       transmit_counter,
  input  wire logic [15:0]       transmit_next_counter,
  input  wire logic [15:0]       receive_counter,
  input  wire logic [15:0]       receive_next_counter,
  output logic [DATA_W-1:0]      status_flags,
  output logic                   irq
);
  chim_req_t   req;
  chim_cnt_t   cnt;
  chim_sel_t   sel;
  logic        transmit_buffers_empty;
  logic        receive_buffers_full;
  logic [31:0] status_w;
  logic [31:0] mask_d;
  logic [31:0] mask_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  always_comb begin
    req.wr    = reg_wr;
    req.rd    = reg_rd;
    req.addr  = reg_addr;
    req.wdata = reg_wdata;
    cnt.tx_cur  = transmit_counter;
    cnt.tx_next = transmit_next_counter;
    cnt.rx_cur  = receive_counter;
    cnt.rx_next = receive_next_counter;
  end

  chim_decode u_decode (
    .addr (req.addr),
    .sel  (sel)
  );

  chim_buf_flags #(
    .CNT_W (16)
  ) u_buf_flags (
    .tx_cur   (cnt.tx_cur),
    .tx_next  (cnt.tx_next),
    .rx_cur   (cnt.rx_cur),
    .rx_next  (cnt.rx_next),
    .tx_empty (transmit_buffers_empty),
    .rx_full  (receive_buffers_full)
  );

  // status word assembly
  always_comb begin
    status_w                = ZERO_WORD;
    status_w[BIT_CMD_DONE]  = command_done;
    status_w[BIT_RX_RDY]    = receive_word_ready;
    status_w[BIT_TX_RDY]    = transmit_word_ready;
    status_w[BIT_BLK_END]   = block_ended;
    status_w[BIT_XFER_ACT]  = data_transfer_active;
    status_w[BIT_IDLE]      = card_idle;
    status_w[BIT_RX_END]    = receive_count_end;
    status_w[BIT_TX_END]    = transmit_count_end;
    status_w[BIT_SLOT_A]    = card_irq_slot_a;
    status_w[BIT_SLOT_B]    = card_irq_slot_b;
    status_w[BIT_RX_FULL]   = receive_buffers_full;
    status_w[BIT_TX_EMPTY]  = transmit_buffers_empty;
    status_w[BIT_RSP_IDX]   = response_index_error;
    status_w[BIT_RSP_DIR]   = response_direction_error;
    status_w[BIT_RSP_CRC]   = response_crc_error;
    status_w[BIT_RSP_END]   = response_endbit_error;
    status_w[BIT_RSP_TMO]   = response_timeout_error;
    status_w[BIT_DAT_CRC]   = data_crc_error;
    status_w[BIT_DAT_TMO]   = data_timeout_error;
    status_w[BIT_OVERRUN]   = receive_overrun;
    status_w[BIT_UNDERRUN]  = transmit_underrun;
  end

  // mask set/clear
  always_comb begin
    mask_d = mask_q;
    if (req.wr && sel == SEL_SET) begin
      mask_d = mask_q | (req.wdata & MASK_IMPL);
    end else if (req.wr && sel == SEL_CLR) begin
      mask_d = mask_q & ~(req.wdata & MASK_IMPL);
    end
  end

  // read data mux, one cycle latency
  always_comb begin
    rdata_d = ZERO_WORD;
    if (req.rd) begin
      case (sel)
        SEL_MASK:   rdata_d = mask_q;
        SEL_STATUS: rdata_d = status_w;
        SEL_COUNT:  rdata_d = {cnt.tx_cur, cnt.rx_cur};
        default:    rdata_d = ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mask_q  <= MASK_RESET;
      rdata_q <= ZERO_WORD;
    end else begin
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign status_flags = status_w;
  assign irq          = |(status_w & mask_q);

  // checks
  a_enable_sets: assert property (@(posedge core_clk) disable iff (!rstn)
    (reg_wr && reg_addr == OFS_ENABLE_SET)
      |=> ((mask_q & ($past(reg_wdata) & MASK_IMPL))
           == ($past(reg_wdata) & MASK_IMPL)))
    else $error("enable write did not set mask bits");

  a_disable_clears: assert property (@(posedge core_clk) disable iff (!rstn)
    (reg_wr && reg_addr == OFS_ENABLE_CLR)
      |=> ((mask_q & $past(reg_wdata)) == ZERO_WORD))
    else $error("disable write did not clear mask bits");

  a_zero_no_effect: assert property (@(posedge core_clk) disable iff (!rstn)
    (reg_wr && reg_addr == OFS_ENABLE_SET)
      |=> ((mask_q & ~$past(reg_wdata)) == ($past(mask_q) & ~$past(reg_wdata))))
    else $error("enable write disturbed unwritten bits");

  a_mask_readback: assert property (@(posedge core_clk) disable iff (!rstn)
    (reg_rd && reg_addr == OFS_MASK_VIEW) |=> (reg_rdata == $past(mask_q)))
    else $error("mask read data wrong");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    (mask_q & ~MASK_IMPL) == ZERO_WORD)
    else $error("reserved mask bit set");

  a_tx_empty_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    status_flags[BIT_TX_EMPTY]
      == (transmit_counter == 16'h0000 && transmit_next_counter == 16'h0000))
    else $error("tx empty flag wrong");

  a_rx_full_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    status_flags[BIT_RX_FULL]
      == (receive_counter == 16'h0000 && receive_next_counter == 16'h0000))
    else $error("rx full flag wrong");

  a_irq_level: assert property (@(posedge core_clk) disable iff (!rstn)
    (reg_wr && reg_addr == OFS_ENABLE_SET && reg_wdata[BIT_CMD_DONE]
     && command_done) ##1 command_done |-> irq)
    else $error("irq missing for enabled flag");

  a_error_map: assert property (@(posedge core_clk) disable iff (!rstn)
    status_flags[BIT_DAT_TMO] == data_timeout_error
    && status_flags[BIT_RSP_IDX] == response_index_error)
    else $error("error flag position wrong");
endmodule : chim_top

// ===== hw/chim_pkg.sv
// package: register map, field layout and carriers for the card irq mask unit
package chim_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_ENABLE_SET  = 8'h00;
  localparam logic [7:0] OFS_ENABLE_CLR  = 8'h04;
  localparam logic [7:0] OFS_MASK_VIEW   = 8'h08;
  localparam logic [7:0] OFS_STATUS_VIEW = 8'h0C;
  localparam logic [7:0] OFS_COUNTERS    = 8'h10;

  // field positions
  localparam int unsigned BIT_CMD_DONE  = 0;
  localparam int unsigned BIT_RX_RDY    = 1;
  localparam int unsigned BIT_TX_RDY    = 2;
  localparam int unsigned BIT_BLK_END   = 3;
  localparam int unsigned BIT_XFER_ACT  = 4;
  localparam int unsigned BIT_IDLE      = 5;
  localparam int unsigned BIT_RX_END    = 6;
  localparam int unsigned BIT_TX_END    = 7;
  localparam int unsigned BIT_SLOT_A    = 8;
  localparam int unsigned BIT_SLOT_B    = 9;
  localparam int unsigned BIT_RX_FULL   = 14;
  localparam int unsigned BIT_TX_EMPTY  = 15;
  localparam int unsigned BIT_RSP_IDX   = 16;
  localparam int unsigned BIT_RSP_DIR   = 17;
  localparam int unsigned BIT_RSP_CRC   = 18;
  localparam int unsigned BIT_RSP_END   = 19;
  localparam int unsigned BIT_RSP_TMO   = 20;
  localparam int unsigned BIT_DAT_CRC   = 21;
  localparam int unsigned BIT_DAT_TMO   = 22;
  localparam int unsigned BIT_OVERRUN   = 30;
  localparam int unsigned BIT_UNDERRUN  = 31;

  // implemented mask positions, others reserved
  localparam logic [31:0] MASK_IMPL     = 32'hC07F_C3FF;
  localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } chim_req_t;

  typedef struct packed {
    logic [15:0] tx_cur;
    logic [15:0] tx_next;
    logic [15:0] rx_cur;
    logic [15:0] rx_next;
  } chim_cnt_t;

  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_SET    = 3'b001,
    SEL_CLR    = 3'b010,
    SEL_MASK   = 3'b011,
    SEL_STATUS = 3'b100,
    SEL_COUNT  = 3'b101
  } chim_sel_t;
endpackage : chim_pkg

// ===== hw/chim_buf_flags.sv
// module: buffer flags derived from transfer counters
`timescale 1ns/1ps
module chim_buf_flags
  import chim_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic [CNT_W-1:0] tx_cur,
  input  wire logic [CNT_W-1:0] tx_next,
  input  wire logic [CNT_W-1:0] rx_cur,
  input  wire logic [CNT_W-1:0] rx_next,
  output logic                  tx_empty,
  output logic                  rx_full
);
  initial begin
    if (CNT_W < 1) $error("chim_buf_flags: CNT_W must be positive");
  end

  function automatic logic both_zero(input logic [CNT_W-1:0] a,
                                     input logic [CNT_W-1:0] b);
    return (a == '0) && (b == '0);
  endfunction : both_zero

  always_comb begin
    tx_empty = both_zero(tx_cur, tx_next);
    rx_full  = both_zero(rx_cur, rx_next);
  end
endmodule : chim_buf_flags

// ===== hw/chim_decode.sv
// module: register address decoder
`timescale 1ns/1ps
module chim_decode
  import chim_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  output chim_sel_t              sel
);
  always_comb begin
    case (addr)
      OFS_ENABLE_SET:  sel = SEL_SET;
      OFS_ENABLE_CLR:  sel = SEL_CLR;
      OFS_MASK_VIEW:   sel = SEL_MASK;
      OFS_STATUS_VIEW: sel = SEL_STATUS;
      OFS_COUNTERS:    sel = SEL_COUNT;
      default:         sel = SEL_NONE;
    endcase
  end
endmodule : chim_decode

// ===== tb/chim_top_tb.sv
// testbench: mask register and irq checks for the card irq mask unit
`timescale 1ns/1ps
module chim_top_tb;
  import chim_pkg::*;
  logic              core_clk;
  logic              rstn;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic [31:0]       flg;
  logic [15:0]       tx_c;
  logic [15:0]       tx_n;
  logic [15:0]       rx_c;
  logic [15:0]       rx_n;
  logic [DATA_W-1:0] status_flags;
  logic              irq;
  logic [31:0]       rv;
  int                fail_count;
  int                cmp_count;

  chim_top DUT (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .command_done(flg[0]),
    .receive_word_ready(flg[1]), .transmit_word_ready(flg[2]),
    .block_ended(flg[3]), .data_transfer_active(flg[4]),
    .card_idle(flg[5]), .receive_count_end(flg[6]),
    .transmit_count_end(flg[7]), .card_irq_slot_a(flg[8]),
    .card_irq_slot_b(flg[9]), .response_index_error(flg[16]),
    .response_direction_error(flg[17]), .response_crc_error(flg[18]),
    .response_endbit_error(flg[19]), .response_timeout_error(flg[20]),
    .data_crc_error(flg[21]), .data_timeout_error(flg[22]),
    .receive_overrun(flg[30]), .transmit_underrun(flg[31]),
    .transmit_counter(tx_c), .transmit_next_counter(tx_n),
    .receive_counter(rx_c), .receive_next_counter(rx_n),
    .status_flags(status_flags), .irq(irq)
  );

  always #10 core_clk = ~core_clk;

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd

  task automatic t_reset;
    @(posedge core_clk);
    flg <= 32'hFFFF_FFFF;
    @(negedge core_clk);
    chk1(irq, 1'b0);
    rd(OFS_MASK_VIEW, rv);
    chk32(rv, MASK_RESET);
    @(negedge core_clk);
    chk32(reg_rdata, ZERO_WORD);
    chk32(status_flags, 32'hC07F_03FF);
    rd(OFS_STATUS_VIEW, rv);
    chk32(rv, 32'hC07F_03FF);
    rd(OFS_COUNTERS, rv);
    chk32(rv, 32'h0001_0001);
    @(posedge core_clk);
    flg <= ZERO_WORD;
  endtask : t_reset

  task automatic t_setclr;
    wr(OFS_ENABLE_SET, 32'hFFFF_FFFF);
    rd(OFS_MASK_VIEW, rv);
    chk32(rv, MASK_IMPL);
    wr(OFS_ENABLE_CLR, 32'h0000_00FF);
    wr(OFS_ENABLE_CLR, ZERO_WORD);
    wr(OFS_ENABLE_SET, ZERO_WORD);
    rd(OFS_MASK_VIEW, rv);
    chk32(rv, MASK_IMPL & 32'hFFFF_FF00);
    wr(OFS_ENABLE_CLR, 32'hFFFF_FFFF);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(OFS_MASK_VIEW, rv);
    chk32(rv, ZERO_WORD);
    rd(8'h40, rv);
    chk32(rv, ZERO_WORD);
    rd(OFS_ENABLE_SET, rv);
    chk32(rv, ZERO_WORD);
  endtask : t_setclr

  task automatic t_map;
    wr(OFS_ENABLE_SET, 32'hFFFF_FFFF);
    for (int i = 0; i < 32; i++) begin
      if (MASK_IMPL[i] && i != 14 && i != 15) begin
        @(posedge core_clk);
        flg <= 32'h1 << i;
        @(negedge core_clk);
        chk32(status_flags, 32'h1 << i);
        chk1(irq, 1'b1);
        wr(OFS_ENABLE_CLR, 32'h1 << i);
        @(negedge core_clk);
        chk1(irq, 1'b0);
        wr(OFS_ENABLE_SET, 32'h1 << i);
        @(negedge core_clk);
        chk1(irq, 1'b1);
      end
    end
    @(posedge core_clk);
    flg <= ZERO_WORD;
  endtask : t_map

  task automatic t_cnt;
    for (int k = 0; k < 5; k++) begin
      @(posedge core_clk);
      tx_c <= (k % 4 == 1) ? 16'h0005 : 16'h0000;
      tx_n <= (k % 4 >= 2) ? 16'h0100 : 16'h0000;
      rx_c <= (k % 4 == 2) ? 16'h0001 : 16'h0000;
      rx_n <= (k % 4 == 1) ? 16'h8000 : 16'h0000;
      @(negedge core_clk);
      chk1(status_flags[BIT_TX_EMPTY], k % 4 == 0);
      chk1(status_flags[BIT_RX_FULL], k % 4 == 0 || k % 4 == 3);
      chk1(irq, k % 4 == 0 || k % 4 == 3);
    end
    wr(OFS_ENABLE_CLR, 32'h0000_8000);
    @(negedge core_clk);
    chk1(irq, 1'b1);
    wr(OFS_ENABLE_CLR, 32'h0000_4000);
    @(negedge core_clk);
    chk1(irq, 1'b0);
  endtask : t_cnt

  task automatic end_sim;
    $display("compares %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (100000) @(posedge core_clk);
    fail_count++;
    end_sim();
  end

  initial begin
    core_clk   = 1'b0;
    rstn       = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = ZERO_WORD;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    flg        = ZERO_WORD;
    tx_c       = 16'h0001;
    tx_n       = 16'h0001;
    rx_c       = 16'h0001;
    rx_n       = 16'h0001;
    fail_count = 0;
    cmp_count  = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_setclr();
    t_map();
    t_cnt();
    end_sim();
  end
endmodule : chim_top_tb
